// ---- dac_cmd_map.svh ----
`ifndef DAC_CMD_MAP_SVH
`define DAC_CMD_MAP_SVH

// frame and word layout
`define FRAME_BITS    5'h18
`define LAST_BIT      5'h17
`define CNT_SAT       5'h19
`define RNW_BIT       23
`define ZERO_BIT      22
`define REG_HI        21
`define REG_LO        19
`define CHAN_HI       18
`define CHAN_LO       16

// register select codes
`define REG_FUNC      3'h0
`define REG_DATA      3'h2
`define REG_CGAIN     3'h3
`define REG_FGAIN     3'h4
`define REG_OFFS      3'h5

// channel select codes; on the function register they pick the command
`define CHAN_A        3'h0
`define CHAN_B        3'h1
`define CHAN_BOTH     3'h4
`define FN_NOP        3'h0
`define FN_CTRL       3'h1
`define FN_CLEAR      3'h4
`define FN_LOAD       3'h5

// control field positions
`define CTL_GND       5
`define CTL_DIR1      4
`define CTL_VAL1      3
`define CTL_DIR0      2
`define CTL_VAL0      1
`define CTL_SDO_DIS   0
`define CTL_RST       6'h00

// clear codes: zero volts in twos complement, negative full scale in binary
`define CLR_TWOS      16'h0000
`define CLR_BIN       16'h0000

// reset image of the synchroniser bank
`define SYNC_RST      8'h98

`endif

// ---- dac_cmd_pkg.sv ----
package dac_cmd_pkg;

	typedef logic [23:0] word_t;
	typedef logic [15:0] data_t;
	typedef logic [2:0]  sel_t;
	typedef logic [5:0]  ctl_t;

endpackage : dac_cmd_pkg

// ---- dual_dac_command_decode.sv ----
`timescale 1ns/1ns
`include "dac_cmd_map.svh"
// ********************************************************************
// ********************************************************************
module dual_dac_command_decode (
	// system
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	// serial link
	input  wire logic                 sclk_i,
	input  wire logic                 sync_n_i,
	input  wire logic                 sdin_i,
	output logic                      serial_data_out_o,
	output logic                      serial_data_out_oe_o,
	// control pins
	input  wire logic                 async_clear_pin_n_i,
	input  wire logic                 load_strobe_n_i,
	input  wire logic                 bin_coding_i,
	// user io pins
	input  wire logic                 user_io_zero_i,
	output logic                      user_io_zero_o,
	output logic                      user_io_zero_oe_o,
	input  wire logic                 user_io_one_i,
	output logic                      user_io_one_o,
	output logic                      user_io_one_oe_o,
	// analog side control
	output logic                      gnd_offset_en_o,
	output logic                      dac_clear_o,
	output logic                      dac_load_o,
	output dac_cmd_pkg::data_t        clear_code_o,
	output logic                      cleared_o,
	// register writes toward the channel registers
	output logic                      wr_valid_o,
	output dac_cmd_pkg::sel_t         wr_reg_o,
	output dac_cmd_pkg::sel_t         wr_chan_o,
	output dac_cmd_pkg::data_t        wr_data_o,
	// readback from the channel registers
	output dac_cmd_pkg::sel_t         rd_reg_o,
	output dac_cmd_pkg::sel_t         rd_chan_o,
	input  wire dac_cmd_pkg::data_t   rd_data_i
);

	// ****************************************************************
	// link domain
	// ****************************************************************
	logic [4:0]          bit_cnt_ff;
	dac_cmd_pkg::word_t  shift_ff;
	logic                word_ok_ff;
	logic                word_tgl_ff;
	dac_cmd_pkg::word_t  rd_word_ff;
	dac_cmd_pkg::ctl_t   ctl_ff;

	// frame select idle resets the count, so a gated clock needs no extra edge
	always_ff @(negedge sclk_i or posedge sync_n_i)
	begin
		if (sync_n_i)
			bit_cnt_ff <= 5'h00;
		else if (bit_cnt_ff != `CNT_SAT)
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
	end

	always_ff @(negedge sclk_i)
	begin
		if (!sync_n_i)
			shift_ff <= {shift_ff[22:0], sdin_i};
	end

	// a frame is good only if its last edge was exactly the 24th
	always_ff @(negedge sclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			word_ok_ff  <= 1'b0;
			word_tgl_ff <= 1'b0;
		end
		else if (!sync_n_i)
		begin
			word_ok_ff <= (bit_cnt_ff == `LAST_BIT);
			if (bit_cnt_ff == `LAST_BIT)
				word_tgl_ff <= ~word_tgl_ff;
		end
	end

	// rd_word_ff only changes after frame select rises, so it is steady
	// across the next frame; beyond 24 edges the input word ripples out
	always_comb
	begin
		if (bit_cnt_ff >= `FRAME_BITS)
			serial_data_out_o = shift_ff[23];
		else
			serial_data_out_o = rd_word_ff[5'h17 - bit_cnt_ff];
	end

	assign serial_data_out_oe_o = !sync_n_i && !ctl_ff[`CTL_SDO_DIS];

	// ****************************************************************
	// synchronisers
	// ****************************************************************
	logic [7:0] meta_ff;
	logic [7:0] sync_ff;
	logic [7:0] async_in;

	assign async_in = {sync_n_i, word_tgl_ff, word_ok_ff, async_clear_pin_n_i,
		load_strobe_n_i, bin_coding_i, user_io_one_i, user_io_zero_i};

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			meta_ff <= `SYNC_RST;
			sync_ff <= `SYNC_RST;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	logic s_sync_n;
	logic s_tgl;
	logic s_ok;
	logic s_clr_n;
	logic s_load_strobe_n_n;
	logic s_bin;
	logic s_io1;
	logic s_io0;

	assign {s_sync_n, s_tgl, s_ok, s_clr_n, s_load_strobe_n_n, s_bin, s_io1, s_io0} = sync_ff;

	// ****************************************************************
	// edge detection
	// ****************************************************************
	logic prev_sync_ff;
	logic prev_clr_ff;
	logic prev_load_strobe_n_ff;
	logic seen_tgl_ff;
	logic commit;

	// prev_clr starts high so a pin held low through reset reads as a fall
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			prev_sync_ff <= 1'b1;
			prev_clr_ff  <= 1'b1;
			prev_load_strobe_n_ff <= 1'b1;
			seen_tgl_ff  <= 1'b0;
		end
		else
		begin
			prev_sync_ff <= s_sync_n;
			prev_clr_ff  <= s_clr_n;
			prev_load_strobe_n_ff <= s_load_strobe_n_n;
			if (s_sync_n && !prev_sync_ff)
				seen_tgl_ff <= s_tgl;
		end
	end

	// a frame with no edges leaves the toggle alone and commits nothing
	assign commit = s_sync_n && !prev_sync_ff && s_ok && (s_tgl != seen_tgl_ff);

	// ****************************************************************
	// word decode
	// ****************************************************************
	logic               w_rnw;
	dac_cmd_pkg::sel_t  w_reg;
	dac_cmd_pkg::sel_t  w_chan;
	dac_cmd_pkg::data_t w_data;
	logic               chan_ok;
	logic               reg_ok;
	logic               is_wr;
	logic               is_rd;
	logic               fn_ctrl;
	logic               fn_clear;
	logic               fn_load;
	logic               ch_write;

	assign w_rnw  = shift_ff[`RNW_BIT];
	assign w_reg  = shift_ff[`REG_HI:`REG_LO];
	assign w_data = shift_ff[15:0];
	assign w_chan = shift_ff[`CHAN_HI:`CHAN_LO];

	assign chan_ok = (w_chan == `CHAN_A) || (w_chan == `CHAN_B)
		|| (w_chan == `CHAN_BOTH);
	assign reg_ok = (w_reg == `REG_DATA) || (w_reg == `REG_CGAIN)
		|| (w_reg == `REG_FGAIN) || (w_reg == `REG_OFFS);

	// the zero bit must be zero, otherwise the word is not a listed code
	assign is_wr = commit && !w_rnw && !shift_ff[`ZERO_BIT];
	assign is_rd = commit && w_rnw && !shift_ff[`ZERO_BIT];

	// nop falls through every term below and so does nothing
	assign fn_ctrl  = is_wr && (w_reg == `REG_FUNC) && (w_chan == `FN_CTRL);
	assign fn_clear = is_wr && (w_reg == `REG_FUNC) && (w_chan == `FN_CLEAR);
	assign fn_load  = is_wr && (w_reg == `REG_FUNC) && (w_chan == `FN_LOAD);
	assign ch_write = is_wr && reg_ok && chan_ok;

	// ****************************************************************
	// control field
	// ****************************************************************
	logic io_out;

	// either direction bit turns both pins round together
	assign io_out = ctl_ff[`CTL_DIR1] || ctl_ff[`CTL_DIR0];

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			ctl_ff <= `CTL_RST;
		else if (fn_ctrl)
		begin
			ctl_ff[`CTL_GND]     <= w_data[`CTL_GND];
			ctl_ff[`CTL_DIR1]    <= w_data[`CTL_DIR1];
			ctl_ff[`CTL_DIR0]    <= w_data[`CTL_DIR0];
			ctl_ff[`CTL_SDO_DIS] <= w_data[`CTL_SDO_DIS];
			// values written while both pins stay inputs are dropped
			if (w_data[`CTL_DIR1] || w_data[`CTL_DIR0])
			begin
				ctl_ff[`CTL_VAL1] <= w_data[`CTL_VAL1];
				ctl_ff[`CTL_VAL0] <= w_data[`CTL_VAL0];
			end
		end
	end

	assign gnd_offset_en_o   = ctl_ff[`CTL_GND];
	assign user_io_one_o     = ctl_ff[`CTL_VAL1];
	assign user_io_zero_o    = ctl_ff[`CTL_VAL0];
	assign user_io_one_oe_o  = io_out;
	assign user_io_zero_oe_o = io_out;

	// ****************************************************************
	// readback
	// ****************************************************************
	logic               rd_fetch_ff;
	logic [7:0]         rd_head_ff;
	dac_cmd_pkg::data_t ctl_rd;

	// value bits show the pins themselves while they are inputs
	assign ctl_rd = {10'h000, ctl_ff[`CTL_GND], ctl_ff[`CTL_DIR1],
		io_out ? ctl_ff[`CTL_VAL1] : s_io1, ctl_ff[`CTL_DIR0],
		io_out ? ctl_ff[`CTL_VAL0] : s_io0, ctl_ff[`CTL_SDO_DIS]};

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			rd_fetch_ff <= 1'b0;
			rd_head_ff  <= 8'h00;
			rd_reg_o    <= `REG_FUNC;
			rd_chan_o   <= `CHAN_A;
			rd_word_ff  <= 24'h000000;
		end
		else
		begin
			rd_fetch_ff <= is_rd && reg_ok && chan_ok;
			if (is_rd && reg_ok && chan_ok)
			begin
				rd_reg_o   <= w_reg;
				rd_chan_o  <= w_chan;
				rd_head_ff <= shift_ff[23:16];
			end
			if (is_rd && (w_reg == `REG_FUNC))
				rd_word_ff <= {shift_ff[23:16], ctl_rd};
			else if (rd_fetch_ff)
				rd_word_ff <= {rd_head_ff, rd_data_i};
		end
	end

	// ****************************************************************
	// channel register writes
	// ****************************************************************
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			wr_valid_o <= 1'b0;
			wr_reg_o   <= `REG_FUNC;
			wr_chan_o  <= `CHAN_A;
			wr_data_o  <= 16'h0000;
		end
		else
		begin
			wr_valid_o <= ch_write;
			if (ch_write)
			begin
				wr_reg_o  <= w_reg;
				wr_chan_o <= w_chan;
				wr_data_o <= w_data;
			end
		end
	end

	// ****************************************************************
	// clear and load
	// ****************************************************************
	logic clr_evt;
	logic load_evt;
	logic data_wr;

	assign clr_evt  = (!s_clr_n && prev_clr_ff) || fn_clear;
	assign data_wr  = ch_write && (w_reg == `REG_DATA);
	// strobe low during a data write updates at once, else at its fall
	assign load_evt = (!s_load_strobe_n_n && prev_load_strobe_n_ff) || fn_load
		|| (data_wr && !s_load_strobe_n_n);

	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
		begin
			dac_clear_o  <= 1'b0;
			dac_load_o   <= 1'b0;
			clear_code_o <= `CLR_TWOS;
		end
		else
		begin
			dac_clear_o  <= clr_evt;
			dac_load_o   <= load_evt;
			clear_code_o <= s_bin ? `CLR_BIN : `CLR_TWOS;
		end
	end

	// a clear in the same cycle as a new data word wins
	always_ff @(posedge clk_i)
	begin
		if (!resetn_i)
			cleared_o <= 1'b0;
		else if (clr_evt)
			cleared_o <= 1'b1;
		else if (data_wr)
			cleared_o <= 1'b0;
	end

endmodule : dual_dac_command_decode

// ---- dac_decode_checker.sv ----
`timescale 1ns/1ns
// ****
// decode checker
// ****
module dac_decode_checker (
	// system
	input wire logic		clk_i,
	input wire logic		resetn_i,
	// pins
	input wire logic		sync_n_i,
	input wire logic		async_clear_pin_n_i,
	input wire logic		load_strobe_n_i,
	// outputs
	input wire logic		serial_data_out_oe_o,
	input wire logic		user_io_zero_oe_o,
	input wire logic		user_io_one_oe_o,
	input wire logic		dac_clear_o,
	input wire logic		dac_load_o,
	input wire logic		cleared_o,
	input wire logic		wr_valid_o,
	input wire dac_cmd_pkg::data_t	clear_code_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	sequence clr_seq;
		cleared_o ##1 (cleared_o || wr_valid_o);
	endsequence
	oe_idle_a: assert property (sync_n_i |-> !serial_data_out_oe_o)
		else $error("sdo enabled outside frame");
	io_oe_pair_a: assert property (user_io_zero_oe_o == user_io_one_oe_o)
		else $error("io enables differ");
	clr_pulse_a: assert property (dac_clear_o |=> !dac_clear_o)
		else $error("clear pulse too long");
	load_pulse_a: assert property (dac_load_o |=> !dac_load_o)
		else $error("load pulse too long");
	wr_pulse_a: assert property (wr_valid_o |=> !wr_valid_o)
		else $error("write pulse too long");
	clr_hold_a: assert property (dac_clear_o |-> clr_seq)
		else $error("cleared level missing");
	pin_clr_a: assert property ($fell(async_clear_pin_n_i) |-> ##[1:6] dac_clear_o)
		else $error("pin clear lost");
	strobe_ld_a: assert property ($fell(load_strobe_n_i) |-> ##[1:6] dac_load_o)
		else $error("strobe load lost");
	clr_code_a: assert property (dac_clear_o |-> clear_code_o == 16'h0000)
		else $error("bad clear code");
endmodule : dac_decode_checker

bind dual_dac_command_decode dac_decode_checker checks (.*);

// ---- host_model.sv ----
`timescale 1ns/1ns
// ****
// host serial port
// ****
module host_model (
	// link
	output logic		sclk_o,
	output logic		sync_n_o,
	output logic		sdin_o,
	input  wire logic	sdo_i,
	input  wire logic	sdo_oe_i
);
	initial
	begin
		sclk_o = 1'b1;
		sync_n_o = 1'b1;
		sdin_o = 1'b0;
	end
	// clock stands high between frames; data line flips once released
	task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] rx,
		output logic oe);
		rx = 24'h000000;
		oe = 1'b0;
		#7 sync_n_o = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			sdin_o = w[23 - (i % 24)];
			#40;
			rx = {rx[22:0], sdo_i};
			oe = oe | sdo_oe_i;
			sclk_o = 1'b0;
			#40 sclk_o = 1'b1;
		end
		#40 sync_n_o = 1'b1;
		sdin_o = ~sdin_o;
		#200;
	endtask : xfer
endmodule : host_model

// ---- test_dual_dac_command_decode.sv ----
`timescale 1ns/1ns
module test_dual_dac_command_decode;
	logic			clk_i, resetn_i, sclk_i, sync_n_i, sdin_i, bin_coding_i;
	logic			async_clear_pin_n_i, load_strobe_n_i, io0_drv, io1_drv;
	logic			serial_data_out_o, serial_data_out_oe_o, gnd_offset_en_o;
	logic			user_io_zero_o, user_io_zero_oe_o, user_io_one_o, user_io_one_oe_o;
	logic			dac_clear_o, dac_load_o, cleared_o, wr_valid_o, oe_seen;
	dac_cmd_pkg::data_t	clear_code_o, wr_data_o, rd_data_i;
	dac_cmd_pkg::sel_t	wr_reg_o, wr_chan_o, rd_reg_o, rd_chan_o;
	logic [23:0]		rx, w;
	int			bad_count = 0, compares = 0, n_clr = 0, n_ld = 0, n_wr = 0;
	wire logic		user_io_zero_i = user_io_zero_oe_o ? user_io_zero_o : io0_drv;
	wire logic		user_io_one_i = user_io_one_oe_o ? user_io_one_o : io1_drv;
	dac_cmd_pkg::sel_t	regs [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
	dac_cmd_pkg::sel_t	chans [4] = '{3'h0, 3'h1, 3'h4, 3'h1};
	logic [23:0]		bad_w [6] = '{24'h410000, 24'h090000, 24'h120000, 24'h02003F,
					24'h110000, 24'h110000};
	int			bad_n [6] = '{24, 24, 24, 24, 23, 25};

	dual_dac_command_decode dut (.*);
	host_model host (
		.sclk_o(sclk_i),
		.sync_n_o(sync_n_i),
		.sdin_o(sdin_i),
		.sdo_i(serial_data_out_o),
		.sdo_oe_i(serial_data_out_oe_o)
	);
	// ****
	// helpers
	// ****
	always @(posedge clk_i)
	begin
		if (dac_clear_o === 1'b1) n_clr++;
		if (dac_load_o === 1'b1) n_ld++;
		if (wr_valid_o === 1'b1) n_wr++;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	// pulse counters restart per word so each check sees only that word
	task automatic send_word(input logic [23:0] fw, input int n);
		n_clr = 0;
		n_ld = 0;
		n_wr = 0;
		host.xfer(fw, n, rx, oe_seen);
		step(10);
	endtask : send_word
	task print_verdict;
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		#200000;
		bad_count++;
		print_verdict();
	end
	// ****
	// tests
	// ****
	initial
	begin
		resetn_i = 1'b0;
		async_clear_pin_n_i = 1'b0;
		load_strobe_n_i = 1'b1;
		bin_coding_i = 1'b0;
		io0_drv = 1'b1;
		io1_drv = 1'b0;
		rd_data_i = 16'h1234;
		step(2);
		resetn_i = 1'b1;
		step(8);
		chk("power-on clear", 24'h1, 24'(n_clr));
		chk("cleared", 24'h1, 24'(cleared_o));
		chk("power-on code", 24'h0, 24'(clear_code_o));
		chk("gnd default", 24'h0, 24'(gnd_offset_en_o));
		chk("io dir default", 24'h0, 24'(user_io_zero_oe_o));
		async_clear_pin_n_i = 1'b1;
		step(4);
		send_word(24'h010038, 24);
		chk("gnd set", 24'h1, 24'(gnd_offset_en_o));
		chk("io1 value", 24'h1, 24'(user_io_one_o));
		chk("io0 value", 24'h0, 24'(user_io_zero_o));
		chk("io dir out", 24'h1, 24'(user_io_zero_oe_o));
		send_word(24'h800000, 24);
		send_word(24'h000000, 24);
		chk("ctl readback", 24'h800038, rx);
		chk("sdo on", 24'h1, 24'(oe_seen));
		for (int i = 0; i < 4; i++)
		begin
			w = {2'b00, regs[i], chans[i], 16'hA5C0 | 16'(i)};
			send_word(w, 24);
			chk("write pulses", 24'h1, 24'(n_wr));
			chk("write fields", w, {2'b00, wr_reg_o, wr_chan_o, wr_data_o});
		end
		chk("cleared off", 24'h0, 24'(cleared_o));
		for (int i = 0; i < 6; i++)
		begin
			send_word(bad_w[i], bad_n[i]);
			chk("refused", 24'h0, 24'(n_wr + n_clr + n_ld));
		end
		chk("gnd kept", 24'h1, 24'(gnd_offset_en_o));
		bin_coding_i = 1'b1;
		send_word(24'h040000, 24);
		chk("soft clear", 24'h1, 24'(n_clr));
		chk("cleared on", 24'h1, 24'(cleared_o));
		chk("clear code", 24'h0, 24'(clear_code_o));
		send_word(24'h050000, 24);
		chk("load cmd", 24'h1, 24'(n_ld));
		n_ld = 0;
		load_strobe_n_i = 1'b0;
		step(8);
		chk("strobe load", 24'h1, 24'(n_ld));
		// strobe held low through a data write updates with the write
		send_word(24'h10BEEF, 24);
		chk("strobe write load", 24'h1, 24'(n_ld));
		chk("strobe write", 24'h1, 24'(n_wr));
		chk("cleared off data", 24'h0, 24'(cleared_o));
		load_strobe_n_i = 1'b1;
		n_clr = 0;
		async_clear_pin_n_i = 1'b0;
		step(8);
		chk("pin clear", 24'h1, 24'(n_clr));
		chk("cleared by pin", 24'h1, 24'(cleared_o));
		async_clear_pin_n_i = 1'b1;
		step(4);
		send_word(24'h010001, 24);
		send_word(24'h800000, 24);
		send_word(24'h000000, 24);
		chk("sdo off", 24'h0, 24'(oe_seen));
		send_word(24'h010000, 24);
		send_word(24'h800000, 24);
		send_word(24'h000000, 24);
		chk("pin readback", 24'h800002, rx);
		chk("io dir in", 24'h0, 24'(user_io_one_oe_o));
		send_word(24'h900000, 24);
		send_word(24'h000000, 24);
		chk("data readback", 24'h901234, rx);
		chk("read select", 24'h10, 24'({rd_reg_o, rd_chan_o}));
		chk("cleared kept", 24'h1, 24'(cleared_o));
		print_verdict();
	end
endmodule : test_dual_dac_command_decode
